//--- src/agu_pkg.sv
// Shared constants and carriers for the stack limit and program space address unit.
// Assumes one core clock and a 16-bit data space with 24-bit program words.
package agu_pkg;
	// ==========================================================
	// Address space constants
	localparam logic [15:0] RAM_START = 16'h0800;
	localparam logic [15:0] SP_RESET = 16'h0800;
	localparam logic [15:0] STEP = 16'h0002;
	localparam int EA_MSB = 15;
	localparam int CFG_BIT = 7;
	localparam int VIS_EN_BIT = 2;
	// ==========================================================
	// Register offsets and reset values
	localparam logic [7:0] OFS_LIMIT = 8'h00;
	localparam logic [7:0] OFS_TABLE_PAGE_REG = 8'h04;
	localparam logic [7:0] OFS_VISPAG = 8'h08;
	localparam logic [7:0] OFS_CORE_CONTROL_REG = 8'h0c;
	localparam logic [7:0] OFS_SP = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {STK_DATA, STK_CALL, STK_EXC} stk_kind_type;
	typedef enum logic {ST_IDLE, ST_PC_HI} stk_state_type;
	typedef enum logic [1:0] {PS_NONE, PS_TBLRD, PS_TBLWT, PS_DREAD} ps_kind_type;
	typedef struct packed {
		logic valid;
		logic push;
		logic pop;
		stk_kind_type kind;
		logic [15:0] wdata;
		logic [22:0] pc;
		logic [7:0] status_low_byte;
	} stk_req_type;
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dmem_req_type;
	typedef struct packed {
		logic valid;
		ps_kind_type kind;
		logic high;
		logic byte_op;
		logic [15:0] ea;
		logic [15:0] wdata;
	} ps_req_type;
	typedef struct packed {
		logic valid;
		logic write;
		logic [23:0] addr;
		logic [2:0] be;
		logic [23:0] wdata;
	} pmem_req_type;
	typedef struct packed {
		logic valid;
		logic remapped;
		logic blocked;
		logic [15:0] data;
	} ps_resp_type;
endpackage : agu_pkg

//--- src/stack_check.sv
// Stack address checker: overflow past the limit and underflow below RAM.
// Assumes a word-aligned limit; purely combinational, used by its parent.
`timescale 1ns/1ps
module stack_check import agu_pkg::*; (
	input wire logic [15:0] i_ea,
	input wire logic [15:0] i_limit,
	input wire logic i_limit_valid,
	input wire logic i_check_limit,
	output logic o_overflow,
	output logic o_underflow
);
	// Equality with the limit is still legal; only a word beyond it traps.
	assign o_overflow = i_check_limit && i_limit_valid && (i_ea > i_limit);
	assign o_underflow = i_ea < RAM_START;
endmodule : stack_check

//--- src/prog_addr_gen.sv
// Program space address builder for table operations and visibility remapping.
// Assumes its parent registers the result and qualifies it with a request.
`timescale 1ns/1ps
module prog_addr_gen import agu_pkg::*; (
	input wire ps_kind_type i_kind,
	input wire logic [15:0] i_ea,
	input wire logic [7:0] i_table_page,
	input wire logic [7:0] i_vis_page,
	input wire logic i_vis_enable,
	input wire logic i_table_busy,
	output logic [23:0] o_addr,
	output logic o_remap,
	output logic o_config
);
	function automatic logic [23:0] word_align(input logic [23:0] a);
		return {a[23:1], 1'b0};
	endfunction : word_align

	wire [23:0] table_addr = word_align({i_table_page, i_ea});
	wire [23:0] vis_addr = word_align({1'b0, i_vis_page, i_ea[14:0]});
	wire is_table = (i_kind == PS_TBLRD) || (i_kind == PS_TBLWT);

	assign o_remap = (i_kind == PS_DREAD) && i_ea[EA_MSB] && i_vis_enable &&
		!i_table_busy;
	assign o_addr = is_table ? table_addr : vis_addr;
	assign o_config = is_table && i_table_page[CFG_BIT];
endmodule : prog_addr_gen

//--- src/stack_limit_and_program_space_agu.sv
// Software stack engine with limit checking, and program space address
// generation for table operations and read-only program space visibility.
// Assumes a single-clock pipeline that drives requests only while ready,
// a program memory that answers each read with i_pmem_rvalid, and an
// AHB-Lite master for the control registers.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module stack_limit_and_program_space_agu import agu_pkg::*; #(
	parameter logic [23:0] CFG_IMPL_LO = 24'h800000,
	parameter logic [23:0] CFG_IMPL_HI = 24'h8000ff
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [31:0] o_hrdata,
	input wire stk_req_type i_stk,
	output logic o_stk_ready,
	input wire logic i_sp_load,
	input wire logic [15:0] i_sp_wdata,
	input wire logic i_sp_ea_valid,
	input wire logic [15:0] i_sp_ea,
	output dmem_req_type o_dmem,
	output logic o_stack_trap,
	input wire ps_req_type i_ps,
	output logic o_ps_ready,
	output pmem_req_type o_pmem,
	input wire logic i_pmem_rvalid,
	input wire logic [23:0] i_pmem_rdata,
	output ps_resp_type o_ps_resp
);
	// ==========================================================
	// Register bus
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [15:1] limit_r;
	logic limit_valid_r;
	logic [7:0] table_page_reg_r;
	logic [7:0] vispag_r;
	logic vis_en_r;
	logic [7:0] trap_count_r;
	logic [31:0] hrdata_r;
	logic [15:0] sp_r;
	logic tbl_busy_r;
	stk_state_type state_r;

	wire addr_phase = i_hsel && i_hready && i_htrans[1];
	wire [7:0] bus_addr = i_haddr[7:0];
	wire [15:0] limit_word = {limit_r, 1'b0};
	wire [15:0] core_control_reg_word = {13'h0000, vis_en_r, 2'b00};
	wire [15:0] status_word = {trap_count_r, 5'h00, state_r == ST_PC_HI, tbl_busy_r,
		limit_valid_r};
	wire [15:0] rd_word = (bus_addr == OFS_LIMIT) ? limit_word :
		(bus_addr == OFS_TABLE_PAGE_REG) ? {8'h00, table_page_reg_r} :
		(bus_addr == OFS_VISPAG) ? {8'h00, vispag_r} :
		(bus_addr == OFS_CORE_CONTROL_REG) ? core_control_reg_word :
		(bus_addr == OFS_SP) ? sp_r :
		(bus_addr == OFS_STATUS) ? status_word : 16'h0000;
	wire wr_limit = wr_pend_r && (wr_addr_r == OFS_LIMIT);
	wire wr_table_page_reg = wr_pend_r && (wr_addr_r == OFS_TABLE_PAGE_REG);
	wire wr_vispag = wr_pend_r && (wr_addr_r == OFS_VISPAG);
	wire wr_core_control_reg = wr_pend_r && (wr_addr_r == OFS_CORE_CONTROL_REG);

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
		end else begin
			wr_pend_r <= addr_phase && i_hwrite;
			wr_addr_r <= bus_addr;
			if (addr_phase && !i_hwrite) begin
				hrdata_r <= {16'h0000, rd_word};
			end
		end
	end

	// The limit keeps no reset value; overflow checks wait for its first write.
	// A new limit acts from the edge that ends the write data phase, so a stack
	// push issued in that same cycle still sees the old limit.
	always_ff @(posedge i_mclk) begin
		if (wr_limit) begin
			limit_r <= i_hwdata[15:1];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			limit_valid_r <= 1'b0;
			table_page_reg_r <= PAGE_RESET;
			vispag_r <= PAGE_RESET;
			vis_en_r <= 1'b0;
		end else begin
			limit_valid_r <= limit_valid_r || wr_limit;
			if (wr_table_page_reg) begin
				table_page_reg_r <= i_hwdata[7:0];
			end
			if (wr_vispag) begin
				vispag_r <= i_hwdata[7:0];
			end
			if (wr_core_control_reg) begin
				vis_en_r <= i_hwdata[VIS_EN_BIT];
			end
		end
	end

	// ==========================================================
	// Stack engine
	stk_state_type state_nxt;
	logic [15:0] sp_nxt;
	logic [15:0] hi_word_r;
	logic [15:0] hi_word_nxt;
	dmem_req_type dmem_r;
	dmem_req_type dmem_nxt;
	logic trap_r;
	logic trap_nxt;
	logic stk_ready_r;
	logic ovf_stk;
	logic und_stk;
	logic ovf_ea;
	logic und_ea;

	wire stk_go = i_stk.valid && stk_ready_r;
	wire in_hi = state_r == ST_PC_HI;
	wire stk_push = in_hi || (stk_go && i_stk.push);
	wire [15:0] stk_ea = (stk_go && i_stk.pop) ? 16'(sp_r - STEP) : sp_r;
	wire stk_fault = (in_hi || stk_go) && (ovf_stk || und_stk);
	wire ea_fault = i_sp_ea_valid && (ovf_ea || und_ea);
	wire is_pc_push = i_stk.kind != STK_DATA;
	wire [15:0] lo_word = is_pc_push ? i_stk.pc[15:0] : i_stk.wdata;
	wire [15:0] call_hi = {9'h000, i_stk.pc[22:16]};
	wire [15:0] exc_hi = {i_stk.status_low_byte, 1'b0, i_stk.pc[22:16]};

	stack_check u_chk_stk (
		.i_ea(stk_ea),
		.i_limit(limit_word),
		.i_limit_valid(limit_valid_r),
		.i_check_limit(stk_push),
		.o_overflow(ovf_stk),
		.o_underflow(und_stk)
	);

	stack_check u_chk_ea (
		.i_ea(i_sp_ea),
		.i_limit(limit_word),
		.i_limit_valid(limit_valid_r),
		.i_check_limit(1'b1),
		.o_overflow(ovf_ea),
		.o_underflow(und_ea)
	);

	// A faulting access is dropped and leaves the pointer unchanged.
	always_comb begin
		state_nxt = state_r;
		sp_nxt = sp_r;
		hi_word_nxt = hi_word_r;
		dmem_nxt = '0;
		trap_nxt = stk_fault || ea_fault;
		if (in_hi) begin
			state_nxt = ST_IDLE;
			if (!stk_fault) begin
				dmem_nxt = {1'b1, 1'b1, sp_r, hi_word_r};
				sp_nxt = 16'(sp_r + STEP);
			end
		end else if (stk_go && !stk_fault) begin
			dmem_nxt = {1'b1, i_stk.push, stk_ea, i_stk.push ? lo_word : 16'h0000};
			if (i_stk.push) begin
				sp_nxt = 16'(sp_r + STEP);
				if (is_pc_push) begin
					state_nxt = ST_PC_HI;
					hi_word_nxt = (i_stk.kind == STK_EXC) ? exc_hi : call_hi;
				end
			end else begin
				sp_nxt = stk_ea;
			end
		end else if (!stk_go && i_sp_load) begin
			sp_nxt = {i_sp_wdata[15:1], 1'b0};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			sp_r <= SP_RESET;
			hi_word_r <= 16'h0000;
			dmem_r <= '0;
			trap_r <= 1'b0;
			stk_ready_r <= 1'b1;
			trap_count_r <= COUNT_RESET;
		end else begin
			state_r <= state_nxt;
			sp_r <= sp_nxt;
			hi_word_r <= hi_word_nxt;
			dmem_r <= dmem_nxt;
			trap_r <= trap_nxt;
			stk_ready_r <= state_nxt == ST_IDLE;
			trap_count_r <= 8'(trap_count_r + {7'h00, trap_nxt});
		end
	end

	// ==========================================================
	// Program space access
	logic rd_pend_r;
	logic ps_ready_r;
	logic pend_high_r;
	logic pend_byte_r;
	logic pend_bsel_r;
	logic pend_remap_r;
	pmem_req_type pmem_r;
	pmem_req_type pmem_nxt;
	ps_resp_type resp_r;
	ps_resp_type resp_nxt;
	logic [23:0] ps_addr;
	logic ps_remap;
	logic ps_cfg;

	function automatic logic [15:0] read_select(input logic [23:0] w, input logic hi,
		input logic byte_op, input logic bsel);
		if (hi) begin
			return (byte_op && bsel) ? 16'h0000 : {8'h00, w[23:16]};
		end
		if (byte_op) begin
			return {8'h00, bsel ? w[15:8] : w[7:0]};
		end
		return w[15:0];
	endfunction : read_select

	prog_addr_gen u_pag (
		.i_kind(i_ps.kind),
		.i_ea(i_ps.ea),
		.i_table_page(table_page_reg_r),
		.i_vis_page(vispag_r),
		.i_vis_enable(vis_en_r),
		.i_table_busy(tbl_busy_r),
		.o_addr(ps_addr),
		.o_remap(ps_remap),
		.o_config(ps_cfg)
	);

	wire ps_go = i_ps.valid && ps_ready_r;
	wire is_tblrd = i_ps.kind == PS_TBLRD;
	wire is_tblwt = i_ps.kind == PS_TBLWT;
	wire is_dread = i_ps.kind == PS_DREAD;
	wire cfg_impl = (ps_addr >= CFG_IMPL_LO) && (ps_addr <= CFG_IMPL_HI);
	wire tbl_blocked = ps_cfg && (is_tblwt || !cfg_impl);
	wire tbl_go = ps_go && (is_tblrd || is_tblwt) && !tbl_blocked;
	wire rd_issue = ps_go && ((is_tblrd && !tbl_blocked) || (is_dread && ps_remap));
	wire rd_done = rd_pend_r && i_pmem_rvalid;
	// Table writes reach the upper byte as well as either byte of the low word.
	wire [2:0] wr_be = i_ps.high ? 3'b100 :
		!i_ps.byte_op ? 3'b011 :
		i_ps.ea[0] ? 3'b010 : 3'b001;
	wire [23:0] wr_data = i_ps.high ? {i_ps.wdata[7:0], 16'h0000} :
		i_ps.byte_op ? {8'h00, i_ps.wdata[7:0], i_ps.wdata[7:0]} :
		{8'h00, i_ps.wdata};
	wire [15:0] rd_data = read_select(i_pmem_rdata, pend_high_r, pend_byte_r,
		pend_bsel_r);

	always_comb begin
		pmem_nxt = '0;
		resp_nxt = '0;
		if (rd_done) begin
			resp_nxt = {1'b1, pend_remap_r, 1'b0, rd_data};
		end else if (ps_go && (is_tblrd || is_tblwt) && tbl_blocked) begin
			resp_nxt = {1'b1, 1'b0, 1'b1, 16'h0000};
		end else if (ps_go && is_tblwt) begin
			pmem_nxt = {1'b1, 1'b1, ps_addr, wr_be, wr_data};
			resp_nxt = {1'b1, 1'b0, 1'b0, 16'h0000};
		end else if (rd_issue) begin
			pmem_nxt = {1'b1, 1'b0, ps_addr, 3'b111, 24'h000000};
		end else if (ps_go && is_dread) begin
			resp_nxt = {1'b1, 1'b0, 1'b0, 16'h0000};
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rd_pend_r <= 1'b0;
			ps_ready_r <= 1'b1;
			tbl_busy_r <= 1'b0;
			pend_high_r <= 1'b0;
			pend_byte_r <= 1'b0;
			pend_bsel_r <= 1'b0;
			pend_remap_r <= 1'b0;
			pmem_r <= '0;
			resp_r <= '0;
		end else begin
			rd_pend_r <= rd_issue || (rd_pend_r && !i_pmem_rvalid);
			ps_ready_r <= !(rd_issue || (rd_pend_r && !i_pmem_rvalid));
			tbl_busy_r <= tbl_go || (tbl_busy_r && rd_pend_r);
			if (rd_issue) begin
				pend_high_r <= is_tblrd && i_ps.high;
				pend_byte_r <= i_ps.byte_op;
				pend_bsel_r <= i_ps.ea[0];
				pend_remap_r <= is_dread;
			end
			pmem_r <= pmem_nxt;
			resp_r <= resp_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = hrdata_r;
	assign o_stk_ready = stk_ready_r;
	assign o_dmem = dmem_r;
	assign o_stack_trap = trap_r;
	assign o_ps_ready = ps_ready_r;
	assign o_pmem = pmem_r;
	assign o_ps_resp = resp_r;

	// ==========================================================
	// Assertions
	wire [7:0] stk_srl = i_stk.status_low_byte;
	wire [14:0] ea_word = i_ps.ea[15:1];
	wire [13:0] ea_vis = i_ps.ea[14:1];
	wire [7:0] pdata_hi = i_pmem_rdata[23:16];

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence s_call_push;
		stk_go && i_stk.push && (i_stk.kind == STK_CALL) && !stk_fault;
	endsequence
	sequence s_exc_push;
		stk_go && i_stk.push && (i_stk.kind == STK_EXC) && !stk_fault;
	endsequence
	sequence s_hi_write;
		in_hi && !stk_fault;
	endsequence

	a_sp_aligned: assert property (!sp_r[0])
		else $error("stack pointer lost word alignment");
	a_push_step: assert property ((stk_go && i_stk.push && !stk_fault) |=>
		o_dmem.valid && o_dmem.write && (o_dmem.addr == $past(sp_r)) &&
		(sp_r == 16'($past(sp_r) + STEP)))
		else $error("push did not write at pointer then step up");
	a_pop_step: assert property ((stk_go && i_stk.pop && !stk_fault) |=>
		o_dmem.valid && !o_dmem.write && (o_dmem.addr == 16'($past(sp_r) - STEP)) &&
		(sp_r == o_dmem.addr))
		else $error("pop did not step down before read");
	a_call_zero: assert property (s_call_push ##1 s_hi_write |=>
		o_dmem.valid && (o_dmem.wdata[15:7] == 9'h000))
		else $error("call push high word not zero extended");
	a_exc_status: assert property (s_exc_push ##1 s_hi_write |=>
		o_dmem.valid && (o_dmem.wdata[15:8] == $past(stk_srl, 2)))
		else $error("exception push lost status low byte");
	a_limit_lsb: assert property ((addr_phase && !i_hwrite && (bus_addr == OFS_LIMIT))
		|=> !o_hrdata[0])
		else $error("limit read shows bit zero set");
	a_limit_equal: assert property ((stk_go && i_stk.push && limit_valid_r &&
		(sp_r == limit_word) && (sp_r >= RAM_START) && !ea_fault) |=> !o_stack_trap)
		else $error("push at limit raised a trap");
	a_over_trap: assert property ((stk_go && i_stk.push && limit_valid_r &&
		(sp_r > limit_word)) |=> o_stack_trap && !o_dmem.valid)
		else $error("push beyond limit not trapped");
	a_under_trap: assert property ((i_sp_ea_valid && (i_sp_ea < RAM_START)) |=>
		o_stack_trap)
		else $error("address below RAM start not trapped");
	a_table_addr: assert property ((tbl_go) |=> o_pmem.valid &&
		(o_pmem.addr == {$past(table_page_reg_r), $past(ea_word), 1'b0}))
		else $error("table address wrong");
	a_vis_addr: assert property ((ps_go && is_dread && vis_en_r &&
		i_ps.ea[EA_MSB] && !tbl_busy_r) |=> o_pmem.valid && !o_pmem.write &&
		(o_pmem.addr == {1'b0, $past(vispag_r), $past(ea_vis), 1'b0}))
		else $error("visibility address wrong");
	a_vis_suspend: assert property ((ps_go && is_dread && tbl_busy_r) |=>
		!o_pmem.valid && o_ps_resp.valid && !o_ps_resp.remapped)
		else $error("remap during table operation");
	a_cfg_nowrite: assert property ((o_pmem.valid && o_pmem.write) |->
		!o_pmem.addr[23])
		else $error("write reached configuration space");
	a_tbl_high: assert property ((rd_done && pend_high_r && !pend_byte_r) |=>
		o_ps_resp.valid && (o_ps_resp.data == {8'h00, $past(pdata_hi)}))
		else $error("upper byte read wrong");
endmodule : stack_limit_and_program_space_agu

//--- sim/pmem_model.sv
// Program memory partner for the address unit: answers every read exactly once.
// Assumes one-cycle request pulses and a delay chosen by the bench per request.
`timescale 1ns/1ps
module pmem_model import agu_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire pmem_req_type i_req,
	input wire logic [1:0] i_delay,
	output logic o_rvalid,
	output logic [23:0] o_rdata
);
	// ==========================================================
	// Read answer
	logic pend_r;
	logic [1:0] cnt_r;
	logic [23:0] addr_r;
	always_ff @(posedge i_clk) begin
		o_rvalid <= 1'b0;
		// Between answers the data lines toggle, so a word sampled one cycle late never matches.
		o_rdata <= ~o_rdata;
		if (i_rst) begin
			pend_r <= 1'b0;
			o_rdata <= 24'h000000;
		end else if (i_req.valid && !i_req.write) begin
			pend_r <= 1'b1;
			cnt_r <= i_delay;
			addr_r <= i_req.addr;
		end else if (pend_r && cnt_r == 2'h0) begin
			pend_r <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= {addr_r[23:16] ^ addr_r[8:1], addr_r[15:0] ^ 16'h3a5c};
		end else if (pend_r) begin
			cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule : pmem_model

//--- sim/stack_limit_and_program_space_agu_tb_top.sv
// Self-checking bench for the stack and program space address unit.
// Assumes the program memory partner model and a zero-wait AHB-Lite slave.
`timescale 1ns/1ps
module stack_limit_and_program_space_agu_tb_top import agu_pkg::*;;
	logic clk, rst, hsel, hwrite, hreadyout, hresp, sp_load, sp_ea_valid, trap, stk_ready;
	logic ps_ready, pm_rvalid, tr, hi, bo;
	logic [31:0] haddr, hwdata, hrdata, rd, seed, r;
	logic [1:0] htrans, delay;
	logic [15:0] sp_wdata, sp_ea, wd, ea, sp;
	logic [23:0] pm_rdata, pa;
	logic [22:0] pc;
	logic [7:0] status_low_byte, pg;
	logic [2:0] be;
	stk_req_type stk;
	ps_req_type ps;
	dmem_req_type dmem, dm, dm2;
	pmem_req_type pmem, pmv;
	ps_resp_type resp, rsp;
	int errors, n_checks, cyc, i;
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	stack_limit_and_program_space_agu dut (.i_mclk(clk), .i_sys_rst(rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
		.i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.o_hrdata(hrdata), .i_stk(stk), .o_stk_ready(stk_ready), .i_sp_load(sp_load),
		.i_sp_wdata(sp_wdata), .i_sp_ea_valid(sp_ea_valid), .i_sp_ea(sp_ea), .o_dmem(dmem),
		.o_stack_trap(trap), .i_ps(ps), .o_ps_ready(ps_ready), .o_pmem(pmem),
		.i_pmem_rvalid(pm_rvalid), .i_pmem_rdata(pm_rdata), .o_ps_resp(resp));
	pmem_model u_pm (.i_clk(clk), .i_rst(rst), .i_req(pmem), .i_delay(delay),
		.o_rvalid(pm_rvalid), .o_rdata(pm_rdata));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [23:0] pm(input logic [23:0] a);
		return {a[23:16] ^ a[8:1], a[15:0] ^ 16'h3a5c};
	endfunction : pm
	function automatic logic [15:0] exp_rd(input logic [23:0] w, input logic h, b, b0);
		if (h) return (b && b0) ? 16'h0000 : {8'h00, w[23:16]};
		if (b) return b0 ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
		return w[15:0];
	endfunction : exp_rd
	task automatic check(input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		check({hresp, hreadyout}, 2'b01);
	endtask : ahb
	task automatic stk_op(input logic pu, input stk_kind_type k, input logic [15:0] w,
		input logic [22:0] p, input logic [7:0] s);
		@(posedge clk);
		stk <= {1'b1, pu, ~pu, k, w, p, s};
		@(posedge clk);
		stk.valid <= 1'b0;
		#1;
		dm = dmem;
		tr = trap;
		if (k != STK_DATA) begin
			check(stk_ready, 1'b0);
			@(posedge clk);
			#1;
			dm2 = dmem;
			check(stk_ready, 1'b1);
		end
	endtask : stk_op
	task automatic sp_check(input logic [15:0] a);
		@(posedge clk);
		sp_ea_valid <= 1'b1;
		sp_ea <= a;
		@(posedge clk);
		sp_ea_valid <= 1'b0;
		#1;
		tr = trap;
	endtask : sp_check
	task automatic ps_op(input ps_kind_type k, input logic h, b, input logic [15:0] a, w);
		int n;
		logic [31:0] x;
		x = rnd();
		@(posedge clk);
		ps <= {1'b1, k, h, b, a, w};
		delay <= x[1:0];
		@(posedge clk);
		ps.valid <= 1'b0;
		#1;
		pmv = pmem;
		check(ps_ready, !(pmv.valid && !pmv.write));
		for (n = 0; n < 20 && resp.valid !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		rsp = resp;
	endtask : ps_op
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			finish_test();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		seed = 32'h0000874e;
		{errors, n_checks, cyc} = '0;
		{rst, hsel, hwrite, sp_load, sp_ea_valid} = 5'b10000;
		{haddr, hwdata, htrans, delay, sp_wdata, sp_ea} = '0;
		stk = '0;
		ps = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		ahb(1'b0, OFS_SP, 32'h0);
		check(rd, {16'h0000, SP_RESET});
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(rd[0], 1'b0);
		ahb(1'b0, 8'h40, 32'h0);
		check(rd, 32'h0);
		ahb(1'b0, OFS_TABLE_PAGE_REG, 32'h0);
		check(rd, PAGE_RESET);
		ahb(1'b1, OFS_LIMIT, 32'h0805);
		ahb(1'b0, OFS_LIMIT, 32'h0);
		check(rd, 32'h0804);
		$display("test reset_and_limit done");
		sp = SP_RESET;
		for (i = 0; i < 4; i++) begin
			r = rnd();
			wd = r[15:0];
			stk_op(1'b1, STK_DATA, wd, 23'h0, 8'h00);
			check(tr, i == 3);
			check(dm.valid, i < 3);
			if (i < 3) check(dm, {2'b11, sp, wd});
			if (i < 3) sp = sp + STEP;
		end
		ahb(1'b0, OFS_SP, 32'h0);
		check(rd, {16'h0000, sp});
		for (i = 0; i < 4; i++) begin
			stk_op(1'b0, STK_DATA, 16'h0, 23'h0, 8'h00);
			check(tr, i == 3);
			if (i < 3) sp = sp - STEP;
			if (i < 3) check({dm.valid, dm.write, dm.addr}, {2'b10, sp});
		end
		$display("test push_pop done");
		// A free cycle always separates a limit write from the next stack access.
		ahb(1'b1, OFS_LIMIT, 32'h0ffe);
		for (i = 0; i < 2; i++) begin
			r = rnd();
			pc = r[22:0];
			status_low_byte = r[30:23];
			stk_op(1'b1, i ? STK_EXC : STK_CALL, 16'h0, pc, status_low_byte);
			check(dm, {2'b11, sp, pc[15:0]});
			check(dm2, {2'b11, sp + STEP,
				i ? {status_low_byte, 1'b0, pc[22:16]} : {9'h0, pc[22:16]}});
			sp = sp + STEP + STEP;
		end
		sp_check(16'h07fe);
		check(tr, 1'b1);
		sp_check(16'h1000);
		check(tr, 1'b1);
		sp_check(16'h0ffe);
		check(tr, 1'b0);
		@(posedge clk);
		sp_load <= 1'b1;
		sp_wdata <= 16'h0ffe;
		@(posedge clk);
		sp_load <= 1'b0;
		stk_op(1'b1, STK_DATA, 16'h1234, 23'h0, 8'h00);
		check({tr, dm}, {3'b011, 16'h0ffe, 16'h1234});
		stk_op(1'b1, STK_DATA, 16'h4321, 23'h0, 8'h00);
		check({tr, dm.valid}, 2'b10);
		$display("test pc_push_and_limits done");
		for (i = 0; i < 16; i++) begin
			r = rnd();
			pg = {1'b0, r[6:0]};
			ea = r[22:7];
			hi = r[23];
			bo = r[24];
			ahb(1'b1, OFS_TABLE_PAGE_REG, {24'h000000, pg});
			ps_op(PS_TBLRD, hi, bo, ea, 16'h0);
			pa = {pg, ea[15:1], 1'b0};
			check({pmv.valid, pmv.write, pmv.addr, pmv.be}, {2'b10, pa, 3'b111});
			check(rsp, {3'b100, exp_rd(pm(pa), hi, bo, ea[0])});
		end
		for (i = 0; i < 4; i++) begin
			r = rnd();
			ea = {r[15:1], i == 2};
			wd = r[31:16];
			hi = (i == 3);
			bo = (i == 1) || (i == 2);
			be = hi ? 3'b100 : bo ? (ea[0] ? 3'b010 : 3'b001) : 3'b011;
			ps_op(PS_TBLWT, hi, bo, ea, wd);
			pa = {pg, ea[15:1], 1'b0};
			check({pmv.valid, pmv.write, pmv.addr, pmv.be}, {2'b11, pa, be});
			if (hi) check(pmv.wdata, {wd[7:0], 16'h0000});
			else check(pmv.wdata, {8'h00, bo ? {wd[7:0], wd[7:0]} : wd});
			check(rsp.valid, 1'b1);
		end
		$display("test table_ops done");
		ahb(1'b1, OFS_TABLE_PAGE_REG, 32'h80);
		ps_op(PS_TBLRD, 1'b0, 1'b0, 16'h0010, 16'h0);
		check({pmv.valid, rsp.blocked}, 2'b10);
		ps_op(PS_TBLWT, 1'b0, 1'b0, 16'h0010, 16'h55aa);
		check({pmv.valid, rsp}, {4'b0101, 16'h0});
		ahb(1'b1, OFS_TABLE_PAGE_REG, 32'h81);
		ps_op(PS_TBLRD, 1'b0, 1'b0, 16'h0010, 16'h0);
		check({pmv.valid, rsp.blocked}, 2'b01);
		ahb(1'b1, OFS_CORE_CONTROL_REG, 32'h1 << VIS_EN_BIT);
		for (i = 0; i < 8; i++) begin
			r = rnd();
			pg = r[7:0];
			ea = {1'b1, r[22:8]};
			ahb(1'b1, OFS_VISPAG, {24'h000000, pg});
			ps_op(PS_DREAD, 1'b0, 1'b0, ea, 16'h0);
			pa = {1'b0, pg, ea[14:1], 1'b0};
			check({pmv.valid, pmv.write, pmv.addr}, {2'b10, pa});
			check(rsp, {3'b110, exp_rd(pm(pa), 1'b0, 1'b0, 1'b0)});
		end
		ps_op(PS_DREAD, 1'b0, 1'b0, 16'h7ffe, 16'h0);
		check({pmv.valid, rsp.valid, rsp.remapped}, 3'b010);
		// A remappable read right behind a table write must not be remapped.
		ahb(1'b1, OFS_TABLE_PAGE_REG, 32'h0);
		@(posedge clk);
		ps <= {1'b1, PS_TBLWT, 2'b00, 16'h0100, 16'h0000};
		@(posedge clk);
		ps <= {1'b1, PS_DREAD, 2'b00, 16'hc000, 16'h0000};
		@(posedge clk);
		ps.valid <= 1'b0;
		#1;
		check({pmem.valid, resp}, {4'b0100, 16'h0000});
		ahb(1'b1, OFS_CORE_CONTROL_REG, 32'h0);
		ps_op(PS_DREAD, 1'b0, 1'b0, 16'hfffe, 16'h0);
		check({pmv.valid, rsp.valid, rsp.remapped}, 3'b010);
		$display("test visibility done");
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(rd[15:8], 8'h05);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		ahb(1'b0, OFS_SP, 32'h0);
		check(rd, {16'h0000, SP_RESET});
		$display("test midrun_reset done");
		finish_test();
	end
endmodule : stack_limit_and_program_space_agu_tb_top
